// [clear_complement_decrement_exec.sv]
`timescale 1ns/10ps

// Overview of operation
// - clear accumulator: zero it, set zero flag
// - complement file, destination bit picks target
// - watchdog clear resets counter and prescaler
// - watchdog clear sets timeout and power-down bits
// - decrement file, destination bit picks target
// - seven-bit file address plus destination bit
module clear_complement_decrement_exec #(
	// widths
	parameter int INSTR_W = 14,
	parameter int DATA_W = 8,
	parameter int FADDR_W = 7
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// instruction
	input wire logic i_instr_valid,
	input wire logic [INSTR_W-1:0] i_instr,
	// operand read from the addressed file register
	input wire logic [DATA_W-1:0] i_file_rdata,
	// file operand address
	output logic [FADDR_W-1:0] o_file_raddr,
	// working accumulator
	output logic [DATA_W-1:0] o_acc,
	// file write-back
	output exec_pkg::file_wr_s o_file_wr,
	// status updates
	output exec_pkg::status_upd_s o_status,
	// watchdog counter and prescaler clear pulse
	output logic o_watchdog_clear,
	// word not handled by this block
	output logic o_unhandled
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (INSTR_W != exec_pkg::INSTR_W) begin : g_instr_w_bad
		$error("instruction width must match the fixed word layout");
	end
	if (DATA_W != exec_pkg::DATA_W) begin : g_data_w_bad
		$error("data width must match the result structs");
	end
	if (FADDR_W != exec_pkg::FADDR_W) begin : g_faddr_w_bad
		$error("file address width must match the write struct");
	end
	if (exec_pkg::DEST_BIT != FADDR_W) begin : g_dest_bit_bad
		$error("destination bit must sit just above the file address");
	end
	if (exec_pkg::OPC_LSB != exec_pkg::DEST_BIT + 1) begin : g_opc_lsb_bad
		$error("opcode field must sit just above the destination bit");
	end
	if (exec_pkg::OPC_MSB != INSTR_W - 1) begin : g_opc_msb_bad
		$error("opcode field must end at the top of the word");
	end
	if (exec_pkg::OPC_MSB - exec_pkg::OPC_LSB != 5) begin : g_opc_w_bad
		$error("opcode field must be six bits wide");
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_CLEAR_ACC = 3'b001,
		OP_WATCHDOG_CLEAR = 3'b010,
		OP_COMPLEMENT = 3'b011,
		OP_DECREMENT = 3'b100,
		OP_OTHER = 3'b101
	} op_kind_e;

	logic clear_accumulator_op;
	logic complement_file_op;
	logic watchdog_clear_op;
	logic decrement_file_op;
	logic dest_sel;
	logic [5:0] opc_field;
	logic [FADDR_W-1:0] file_addr;
	logic [DATA_W-1:0] result;
	logic result_zero;
	op_kind_e op_kind;
	exec_pkg::dest_e dest;
	exec_pkg::exec_state_s state_r;
	exec_pkg::exec_state_s state_nxt;

	assign opc_field = i_instr[exec_pkg::OPC_MSB:exec_pkg::OPC_LSB];
	assign clear_accumulator_op = i_instr_valid
		&& (i_instr == exec_pkg::CLEAR_ACC_WORD);
	assign watchdog_clear_op = i_instr_valid
		&& (i_instr == exec_pkg::WATCHDOG_CLEAR_WORD);
	assign complement_file_op = i_instr_valid
		&& (opc_field == exec_pkg::COMPLEMENT_OPC);
	assign decrement_file_op = i_instr_valid
		&& (opc_field == exec_pkg::DECREMENT_OPC);
	assign dest_sel = i_instr[exec_pkg::DEST_BIT];
	assign file_addr = i_instr[FADDR_W-1:0];
	assign o_file_raddr = file_addr;

	// ----------------------------------------
	// instruction class, fixed priority
	// ----------------------------------------
	always_comb begin
		op_kind = OP_NONE;
		if (clear_accumulator_op) begin
			op_kind = OP_CLEAR_ACC;
		end else if (watchdog_clear_op) begin
			op_kind = OP_WATCHDOG_CLEAR;
		end else if (complement_file_op) begin
			op_kind = OP_COMPLEMENT;
		end else if (decrement_file_op) begin
			op_kind = OP_DECREMENT;
		end else if (i_instr_valid) begin
			op_kind = OP_OTHER;
		end
	end

	// ----------------------------------------
	// byte operation
	// ----------------------------------------
	always_comb begin
		result = exec_pkg::ZERO_BYTE;
		case (op_kind)
			OP_COMPLEMENT: begin
				result = ~i_file_rdata;
			end
			OP_DECREMENT: begin
				result = i_file_rdata - exec_pkg::ONE_BYTE;
			end
			default: begin
				result = exec_pkg::ZERO_BYTE;
			end
		endcase
	end

	// ----------------------------------------
	// zero test of the byte result
	// ----------------------------------------
	assign result_zero = (result == exec_pkg::ZERO_BYTE);

	// ----------------------------------------
	// destination of the byte result
	// ----------------------------------------
	always_comb begin
		dest = exec_pkg::DEST_NONE;
		case (op_kind)
			OP_COMPLEMENT, OP_DECREMENT: begin
				if (dest_sel) begin
					dest = exec_pkg::DEST_FILE;
				end else begin
					dest = exec_pkg::DEST_ACC;
				end
			end
			default: begin
				dest = exec_pkg::DEST_NONE;
			end
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		state_nxt.file_wr = '0;
		state_nxt.status = '0;
		state_nxt.watchdog_clear = 1'b0;
		state_nxt.illegal = 1'b0;
		case (op_kind)
			OP_CLEAR_ACC: begin
				state_nxt.acc = exec_pkg::ZERO_BYTE;
				state_nxt.status.zero_we = 1'b1;
				state_nxt.status.zero_val = 1'b1;
			end
			OP_WATCHDOG_CLEAR: begin
				state_nxt.watchdog_clear = 1'b1;
				state_nxt.status.timeout_status_bit_set = 1'b1;
				state_nxt.status.power_down_status_bit_set = 1'b1;
			end
			OP_COMPLEMENT, OP_DECREMENT: begin
				state_nxt.status.zero_we = 1'b1;
				state_nxt.status.zero_val = result_zero;
			end
			OP_OTHER: begin
				state_nxt.illegal = 1'b1;
			end
			default: begin
				state_nxt.illegal = 1'b0;
			end
		endcase
		case (dest)
			exec_pkg::DEST_ACC: begin
				state_nxt.acc = result;
			end
			exec_pkg::DEST_FILE: begin
				state_nxt.file_wr.valid = 1'b1;
				state_nxt.file_wr.addr = file_addr;
				state_nxt.file_wr.data = result;
			end
			default: begin
				state_nxt.file_wr.valid = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_acc = state_r.acc;
	assign o_file_wr = state_r.file_wr;
	assign o_status = state_r.status;
	assign o_watchdog_clear = state_r.watchdog_clear;
	assign o_unhandled = state_r.illegal;

endmodule : clear_complement_decrement_exec

// [exec_chk.sv]
`timescale 1ns/10ps
module exec_chk (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// instruction and operand
	input wire logic i_instr_valid,
	input wire logic [13:0] i_instr,
	input wire logic [7:0] i_file_rdata,
	// results
	input wire logic [6:0] o_file_raddr,
	input wire logic [7:0] o_acc,
	input wire exec_pkg::file_wr_s o_file_wr,
	input wire exec_pkg::status_upd_s o_status,
	input wire logic o_watchdog_clear,
	input wire logic o_unhandled
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	wire is_comp = i_instr_valid && i_instr[13:8] == 6'h09;
	wire is_dec = i_instr_valid && i_instr[13:8] == 6'h03;
	wire is_wdog = i_instr_valid && i_instr == 14'h0064;
	a_clear_acc: assert property (i_instr_valid && i_instr == 14'h0103 |=>
		o_acc == 8'h00 && o_status.zero_we && o_status.zero_val) else $error("clear acc");
	a_comp_inv: assert property (is_comp && i_instr[7] |=>
		o_file_wr.valid && o_file_wr.data == ~$past(i_file_rdata)) else $error("complement");
	a_comp_acc: assert property (is_comp && !i_instr[7] |=>
		o_acc == ~$past(i_file_rdata) && !o_file_wr.valid) else $error("complement acc");
	a_wdog_pulse: assert property (is_wdog |=>
		o_watchdog_clear) else $error("watchdog clear");
	a_wdog_status: assert property (is_wdog |=> o_status.timeout_status_bit_set &&
		o_status.power_down_status_bit_set && !o_status.zero_we) else $error("watchdog status");
	a_dec_file: assert property (is_dec && i_instr[7] |=>
		o_file_wr.valid && o_file_wr.data == $past(i_file_rdata) - 8'h01) else $error("dec file");
	a_dec_acc: assert property (is_dec && !i_instr[7] |=>
		o_acc == $past(i_file_rdata) - 8'h01 && !o_file_wr.valid) else $error("decrement");
	a_file_addr: assert property ((is_comp || is_dec) && i_instr[7] |=>
		o_file_wr.addr == $past(i_instr[6:0])) else $error("file addr");
	a_zero_flag: assert property (is_comp || is_dec |=> o_status.zero_we &&
		o_status.zero_val == ($past(i_instr[11]) ? $past(i_file_rdata) == 8'hFF :
		$past(i_file_rdata) == 8'h01)) else $error("zero flag");
	c_comp: cover property (is_comp && i_instr[7]);
	c_dec: cover property (is_dec && !i_instr[7]);
	c_wdog: cover property (is_wdog);
	c_clear: cover property (i_instr_valid && i_instr == 14'h0103);
endmodule : exec_chk
bind clear_complement_decrement_exec exec_chk u_chk (
	.i_core_clk(i_core_clk),
	.i_nrst(i_nrst),
	.i_instr_valid(i_instr_valid),
	.i_instr(i_instr),
	.i_file_rdata(i_file_rdata),
	.o_file_raddr(o_file_raddr),
	.o_acc(o_acc),
	.o_file_wr(o_file_wr),
	.o_status(o_status),
	.o_watchdog_clear(o_watchdog_clear),
	.o_unhandled(o_unhandled)
);

// [exec_pkg.sv]
package exec_pkg;

	// ----------------------------------------
	// instruction word layout
	// ----------------------------------------
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int DEST_BIT = 7;
	localparam int OPC_MSB = 13;
	localparam int OPC_LSB = 8;

	// ----------------------------------------
	// opcode patterns
	// ----------------------------------------
	localparam logic [13:0] CLEAR_ACC_WORD = 14'h0103;
	localparam logic [13:0] WATCHDOG_CLEAR_WORD = 14'h0064;
	localparam logic [5:0] COMPLEMENT_OPC = 6'h09;
	localparam logic [5:0] DECREMENT_OPC = 6'h03;

	// ----------------------------------------
	// accumulator reset value and byte constants
	// ----------------------------------------
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;

	typedef enum logic [1:0] {
		DEST_NONE = 2'b00,
		DEST_ACC = 2'b01,
		DEST_FILE = 2'b10
	} dest_e;

	// file write request towards the register file
	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [7:0] data;
	} file_wr_s;

	// status flag updates
	typedef struct packed {
		logic zero_we;
		logic zero_val;
		logic timeout_status_bit_set;
		logic power_down_status_bit_set;
	} status_upd_s;

	// whole registered state
	typedef struct packed {
		logic [7:0] acc;
		file_wr_s file_wr;
		status_upd_s status;
		logic watchdog_clear;
		logic illegal;
	} exec_state_s;

endpackage : exec_pkg

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
	logic i_core_clk = 1'b0, i_nrst = 1'b0, i_instr_valid = 1'b0;
	logic [13:0] i_instr = 14'h0000;
	logic [7:0] i_file_rdata = 8'h00, o_acc;
	logic [6:0] o_file_raddr;
	exec_pkg::file_wr_s o_file_wr;
	exec_pkg::status_upd_s o_status;
	logic o_watchdog_clear, o_unhandled;
	int fail_count = 0, compares = 0, cyc = 0;
	clear_complement_decrement_exec uut (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_instr_valid(i_instr_valid),
		.i_instr(i_instr),
		.i_file_rdata(i_file_rdata),
		.o_file_raddr(o_file_raddr),
		.o_acc(o_acc),
		.o_file_wr(o_file_wr),
		.o_status(o_status),
		.o_watchdog_clear(o_watchdog_clear),
		.o_unhandled(o_unhandled)
	);
	always #2 i_core_clk = ~i_core_clk;
	task chk(input logic [29:0] got, input logic [29:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task run(input logic [13:0] w, input logic [7:0] rd, input logic [29:0] e);
		@(negedge i_core_clk);
		i_instr_valid = 1'b1;
		i_instr = w;
		i_file_rdata = rd;
		#1 chk({23'h0, o_file_raddr}, {23'h0, w[6:0]});
		@(negedge i_core_clk);
		i_instr_valid = 1'b0;
		chk({o_acc, o_file_wr, o_status, o_watchdog_clear, o_unhandled}, e);
		$display("test %h done", w);
	endtask : run
	task final_report;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 200) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		repeat (4) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_nrst = 1'b1;
		chk({o_acc, o_file_wr, o_status, o_watchdog_clear, o_unhandled}, 30'h0);
		run(14'h037F, 8'h00, {8'hFF, 16'h0000, 4'h8, 2'h0});
		run(14'h0103, 8'h5A, {8'h00, 16'h0000, 4'hC, 2'h0});
		run(14'h0985, 8'h13, {8'h00, 16'h85EC, 4'h8, 2'h0});
		run(14'h0955, 8'hA5, {8'h5A, 16'h0000, 4'h8, 2'h0});
		run(14'h097F, 8'hFF, {8'h00, 16'h0000, 4'hC, 2'h0});
		run(14'h0380, 8'h01, {8'h00, 16'h8000, 4'hC, 2'h0});
		run(14'h0300, 8'h80, {8'h7F, 16'h0000, 4'h8, 2'h0});
		run(14'h0064, 8'h00, {8'h7F, 16'h0000, 4'h3, 2'h2});
		run(14'h3FFF, 8'h00, {8'h7F, 16'h0000, 4'h0, 2'h1});
		@(negedge i_core_clk);
		i_nrst = 1'b0;
		#1 chk({o_acc, o_file_wr, o_status, o_watchdog_clear, o_unhandled}, 30'h0);
		@(negedge i_core_clk);
		i_nrst = 1'b1;
		$display("test reset done");
		run(14'h0311, 8'h10, {8'h0F, 16'h0000, 4'h8, 2'h0});
		final_report();
	end
endmodule : testbench
